// [core/dbs_pkg.sv]
/*
 dbs_pkg: constants and state type for the dynamic bus width sizing unit.
 Assumes one clock domain; all bus pins are sampled on the rising edge.
*/
package dbs_pkg;
   // operand length codes on the core request port
   localparam logic [1:0] LEN_BYTE = 2'h0;
   localparam logic [1:0] LEN_WORD = 2'h1;
   localparam logic [1:0] LEN_DWORD = 2'h2;
   // lane masks, active high inside the unit
   localparam logic [3:0] MASK_BYTE = 4'h1;
   localparam logic [3:0] MASK_WORD = 4'h3;
   localparam logic [3:0] MASK_DWORD = 4'hf;
   localparam logic [3:0] LANES_UPPER = 4'hc;
   localparam logic [3:0] LANES_NONE = 4'h0;
   // reset values of the pins and of the wide registers, plus the dword step
   localparam logic [3:0] RST_LANES_N = 4'hf;
   localparam logic [29:0] RST_DWORD = 30'h0;
   localparam logic [31:0] RST_DATA = 32'h0;
   localparam logic [63:0] RST_WIDE = 64'h0;
   localparam logic [29:0] DWORD_STEP = 30'h1;
   // bus cycle states, gray along idle -> t1 -> t2
   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_T1 = 2'h1,
      ST_T2 = 2'h3
   } dbs_state_t;
endpackage

// [core/dbs_sizer.sv]
/*
 dbs_sizer: splits core operand transfers into bus cycles on a 32-bit bus
 whose addressed port may be 16 bits wide, and steers data to the low half.
 Assumes the external decoder drives narrow_port_input_n and ready_n
 synchronously, and that the core holds its request until req_ready.
*/
`timescale 1ns/10ps
module dbs_sizer (
   input wire logic clk,                         // 100 MHz bus clock
   input wire logic rst_n,                       // async reset, active low
   input wire logic req_valid,                   // core transfer request
   input wire logic req_write,                   // 1 write, 0 read
   input wire logic [31:0] req_addr,             // operand byte address
   input wire logic [1:0] req_len,               // byte, word or dword
   input wire logic [31:0] req_wdata,            // operand, byte 0 in bits 7:0
   output logic req_ready,                       // one-cycle completion pulse
   output logic [31:0] req_rdata,                // read operand, valid with req_ready
   output logic bus_start_n,                     // new cycle address strobe
   output logic [29:0] dword_address_lines,      // dword address
   output logic [3:0] byte_lane_selects_n,       // lane enables, active low
   output logic write_read_indicator,            // 1 write cycle
   output logic [31:0] data_out,                 // data bus output side
   output logic data_oe,                         // data bus drive enable
   input wire logic [31:0] data_in,              // data bus input side
   input wire logic ready_n,                     // cycle acknowledge
   input wire logic narrow_port_input_n          // port is 16 bits wide
);
   dbs_pkg::dbs_state_t state, next_state;
   logic write, next_write;
   logic [1:0] offset, next_offset;
   logic [3:0] mask, next_mask;
   logic [3:0] lo_mask, next_lo_mask;
   logic [29:0] dword, next_dword;
   logic pending, next_pending;
   logic on_high, next_on_high;
   logic half2, next_half2;
   logic [63:0] wide, next_wide;
   logic [63:0] acc, next_acc;
   logic next_req_ready;
   logic [31:0] next_req_rdata;
   logic next_bus_start_n;
   logic [29:0] next_dword_address_lines;
   logic [3:0] next_byte_lane_selects_n;
   logic next_write_read_indicator;
   logic [31:0] next_data_out;
   logic next_data_oe;
   logic split;

   // lane mask of an operand length
   function automatic logic [3:0] len_mask(input logic [1:0] len);
      unique case (len)
         dbs_pkg::LEN_BYTE: len_mask = dbs_pkg::MASK_BYTE;
         dbs_pkg::LEN_WORD: len_mask = dbs_pkg::MASK_WORD;
         default: len_mask = dbs_pkg::MASK_DWORD;
      endcase
   endfunction

   // word driven on the pins for a given lane set
   function automatic logic [31:0] bus_word(input logic [31:0] lanes, input logic [3:0] m);
      // upper-only copy: 16-bit port finds data on its lines in one cycle
      if (m[1:0] == 2'h0) begin
         bus_word = {lanes[31:16], lanes[31:16]};
      end else begin
         bus_word = lanes;
      end
   endfunction

   // spanning with narrow port needs a second cycle; lower-only never splits
   assign split = !narrow_port_input_n && !half2 && (mask[1:0] != 2'h0)
                  && (mask[3:2] != 2'h0);

   // sequencing, steering and pin values
   always_comb begin
      logic [7:0] m8;
      logic [31:0] cap;
      logic launch;
      m8 = 8'h0;
      cap = on_high ? acc[63:32] : acc[31:0];
      launch = 1'b0;
      next_state = state;
      next_write = write;
      next_offset = offset;
      next_mask = mask;
      next_lo_mask = lo_mask;
      next_dword = dword;
      next_pending = pending;
      next_on_high = on_high;
      next_half2 = half2;
      next_wide = wide;
      next_acc = acc;
      next_req_ready = 1'b0;
      next_req_rdata = req_rdata;
      next_bus_start_n = 1'b1;
      next_dword_address_lines = dword_address_lines;
      next_byte_lane_selects_n = byte_lane_selects_n;
      next_write_read_indicator = write_read_indicator;
      next_data_out = data_out;
      next_data_oe = data_oe;
      unique case (state)
         dbs_pkg::ST_IDLE: begin
            if (req_valid && !req_ready) begin
               m8 = {4'h0, len_mask(req_len)} << req_addr[1:0];
               next_write = req_write;
               next_offset = req_addr[1:0];
               next_lo_mask = m8[3:0];
               // operand byte i lands on lane (address + i)
               next_wide = {32'h0, req_wdata} << {req_addr[1:0], 3'h0};
               next_acc = dbs_pkg::RST_WIDE;
               next_half2 = 1'b0;
               // misaligned operand: next dword (high bytes) goes first
               if (m8[7:4] != dbs_pkg::LANES_NONE) begin
                  next_pending = 1'b1;
                  next_on_high = 1'b1;
                  next_mask = m8[7:4];
                  next_dword = req_addr[31:2] + dbs_pkg::DWORD_STEP;
               end else begin
                  next_pending = 1'b0;
                  next_on_high = 1'b0;
                  next_mask = m8[3:0];
                  next_dword = req_addr[31:2];
               end
               launch = 1'b1;
            end
         end
         dbs_pkg::ST_T1: begin
            next_state = dbs_pkg::ST_T2;
         end
         dbs_pkg::ST_T2: begin
            if (!ready_n) begin
               // narrow input sampled at each cycle end
               for (int i = 0; i < 4; i++) begin
                  if (mask[i]) begin
                     if (i < 2 || narrow_port_input_n) begin
                        cap[i*8 +: 8] = data_in[i*8 +: 8];
                     // narrow upper-only read: lanes 2/3 come from lower half
                     end else if (mask[1:0] == 2'h0) begin
                        // odd/even lane pick keeps the index in range for every i
                        cap[i*8 +: 8] = data_in[(i & 1)*8 +: 8];
                     end
                     // narrow spanning read: upper half left for second cycle
                  end
               end
               if (on_high) begin
                  next_acc[63:32] = cap;
               end else begin
                  next_acc[31:0] = cap;
               end
               // narrow port: split, then further pieces as needed
               if (split) begin
                  // second half: upper lanes only, low lanes negated
                  next_half2 = 1'b1;
                  next_mask = mask & dbs_pkg::LANES_UPPER;
                  launch = 1'b1;
               end else if (pending) begin
                  next_pending = 1'b0;
                  next_on_high = 1'b0;
                  next_half2 = 1'b0;
                  next_mask = lo_mask;
                  next_dword = dword - dbs_pkg::DWORD_STEP;
                  launch = 1'b1;
               end else begin
                  next_state = dbs_pkg::ST_IDLE;
                  next_req_ready = 1'b1;
                  next_req_rdata = 32'(next_acc >> {offset, 3'h0});
                  next_byte_lane_selects_n = dbs_pkg::RST_LANES_N;
                  next_data_oe = 1'b0;
               end
            end
         end
         default: begin
            next_state = dbs_pkg::ST_IDLE;
         end
      endcase
      // every piece is a fresh cycle started after the last one ended
      if (launch) begin
         next_state = dbs_pkg::ST_T1;
         next_bus_start_n = 1'b0;
         next_dword_address_lines = next_dword;
         // masks come from contiguous shifts, never empty
         next_byte_lane_selects_n = ~next_mask;
         next_write_read_indicator = next_write;
         next_data_oe = next_write;
         // first split write drives all four bytes; second copies
         next_data_out = bus_word(next_on_high ? next_wide[63:32] : next_wide[31:0],
                                  next_mask);
      end
   end

   // state and pin registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= dbs_pkg::ST_IDLE;
         write <= 1'b0;
         offset <= 2'h0;
         mask <= dbs_pkg::LANES_NONE;
         lo_mask <= dbs_pkg::LANES_NONE;
         dword <= dbs_pkg::RST_DWORD;
         pending <= 1'b0;
         on_high <= 1'b0;
         half2 <= 1'b0;
         wide <= dbs_pkg::RST_WIDE;
         acc <= dbs_pkg::RST_WIDE;
         req_ready <= 1'b0;
         req_rdata <= dbs_pkg::RST_DATA;
         bus_start_n <= 1'b1;
         dword_address_lines <= dbs_pkg::RST_DWORD;
         byte_lane_selects_n <= dbs_pkg::RST_LANES_N;
         write_read_indicator <= 1'b0;
         data_out <= dbs_pkg::RST_DATA;
         data_oe <= 1'b0;
      end else begin
         state <= next_state;
         write <= next_write;
         offset <= next_offset;
         mask <= next_mask;
         lo_mask <= next_lo_mask;
         dword <= next_dword;
         pending <= next_pending;
         on_high <= next_on_high;
         half2 <= next_half2;
         wide <= next_wide;
         acc <= next_acc;
         req_ready <= next_req_ready;
         req_rdata <= next_req_rdata;
         bus_start_n <= next_bus_start_n;
         dword_address_lines <= next_dword_address_lines;
         byte_lane_selects_n <= next_byte_lane_selects_n;
         write_read_indicator <= next_write_read_indicator;
         data_out <= next_data_out;
         data_oe <= next_data_oe;
      end
   end

   // checks on the pins the unit drives and on its half2 and acc registers
   sequence s_cycle_end;
      state == dbs_pkg::ST_T2 && !ready_n;
   endsequence

   sequence s_narrow_span;
      s_cycle_end ##0 split;
   endsequence

   a_lane_pattern_legal: assert property (
      @(posedge clk) disable iff (!rst_n)
      !bus_start_n |-> byte_lane_selects_n inside
         {4'he, 4'hd, 4'hb, 4'h7, 4'hc, 4'h9, 4'h3, 4'h8, 4'h1, 4'h0})
      else $error("illegal lane pattern on bus start");

   a_split_second_half: assert property (
      @(posedge clk) disable iff (!rst_n)
      s_narrow_span |=> !bus_start_n && byte_lane_selects_n[1:0] == 2'h3
         && $stable(dword_address_lines))
      else $error("split second cycle wrong");

   a_upper_copy_write: assert property (
      @(posedge clk) disable iff (!rst_n)
      data_oe && byte_lane_selects_n[1:0] == 2'h3 |-> data_out[15:0] == data_out[31:16])
      else $error("upper-only write not copied to lower half");

   a_lower_no_split: assert property (
      @(posedge clk) disable iff (!rst_n)
      s_cycle_end ##0 (byte_lane_selects_n[3:2] == 2'h3) |=> !half2)
      else $error("lower-only cycle was split");

   a_high_piece_first: assert property (
      @(posedge clk) disable iff (!rst_n)
      state == dbs_pkg::ST_IDLE && req_valid && !req_ready
         && ({1'b0, req_addr[1:0]} + ((req_len == dbs_pkg::LEN_BYTE) ? 3'h0
            : (req_len == dbs_pkg::LEN_WORD) ? 3'h1 : 3'h3)) > 3'h3
      |=> dword_address_lines == $past(req_addr[31:2]) + dbs_pkg::DWORD_STEP)
      else $error("misaligned operand not high dword first");

   a_start_one_clock: assert property (
      @(posedge clk) disable iff (!rst_n)
      !bus_start_n |=> bus_start_n ##0 state == dbs_pkg::ST_T2)
      else $error("cycle start longer than one clock");

   a_narrow_read_steer: assert property (
      @(posedge clk) disable iff (!rst_n)
      s_cycle_end ##0 (!narrow_port_input_n && !write && mask == dbs_pkg::LANES_UPPER
         && !on_high) |=> acc[31:16] == $past(data_in[15:0]))
      else $error("narrow upper read not taken from lower half");

   a_write_drive_hold: assert property (
      @(posedge clk) disable iff (!rst_n)
      !bus_start_n && write_read_indicator |-> data_oe [*2])
      else $error("write data not driven through cycle");

   a_done_single_pulse: assert property (
      @(posedge clk) disable iff (!rst_n)
      req_ready |-> $past(state) == dbs_pkg::ST_T2 ##1 !req_ready)
      else $error("completion pulse malformed");
endmodule // dbs_sizer

// [test/dbs_port_model.sv]
/*
 dbs_port_model: address decoder plus a 32-bit array (dwords 0-15) and a
 16-bit array (dwords 16-31) answering the sizer's bus cycles.
 Assumes non-pipelined cycles; slow adds two wait states to each cycle.
*/
`timescale 1ns/10ps
module dbs_port_model (
   input wire logic clk,                    // bus clock
   input wire logic rst_n,                  // async reset, active low
   input wire logic slow,                   // insert wait states
   input wire logic bus_start_n,            // cycle start strobe
   input wire logic [29:0] dword_address_lines, // dword address
   input wire logic [3:0] byte_lane_selects_n,  // lane enables
   input wire logic write_read_indicator,   // 1 write
   input wire logic [31:0] data_out,        // write data
   output logic [31:0] data_in,             // read data
   output logic ready_n,                    // cycle acknowledge
   output logic narrow_port_input_n         // 16-bit port hit
);
   logic [31:0] mem [0:31];
   logic [1:0] wait_cnt;
   logic [3:0] en;
   logic word_address_bit;
   logic low_byte_strobe_n;
   logic high_byte_strobe_n;
   logic [15:0] half;
   logic [4:0] idx;
   assign idx = dword_address_lines[4:0];
   assign en = ~byte_lane_selects_n;
   assign narrow_port_input_n = ~dword_address_lines[4];
   // word bit from lowest enabled lanes
   assign word_address_bit = ~(en[0] | en[1]);
   // byte strobes of the 16-bit port
   assign low_byte_strobe_n = ~(en[0] | (en[2] & word_address_bit));
   assign high_byte_strobe_n = ~(en[1] | (en[3] & word_address_bit));
   assign half = word_address_bit ? mem[idx][31:16] : mem[idx][15:0];
   // acknowledge and memory; released data lines toggle so stale data never matches
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ready_n <= 1'b1;
         data_in <= 32'h0;
         wait_cnt <= 2'h0;
      end else begin
         ready_n <= 1'b1;
         data_in <= ~data_in;
         if (!ready_n && write_read_indicator) begin
            for (int i = 0; i < 4; i++) begin
               if (narrow_port_input_n && en[i]) mem[idx][8*i +: 8] <= data_out[8*i +: 8];
            end
            if (!narrow_port_input_n && !low_byte_strobe_n)
               mem[idx][16*word_address_bit +: 8] <= data_out[7:0];
            if (!narrow_port_input_n && !high_byte_strobe_n)
               mem[idx][16*word_address_bit+8 +: 8] <= data_out[15:8];
         end
         if (!bus_start_n && slow) begin
            wait_cnt <= 2'h2;
         end else if ((!bus_start_n) || (wait_cnt == 2'h1)) begin
            wait_cnt <= 2'h0;
            ready_n <= 1'b0;
            data_in <= narrow_port_input_n ? mem[idx] : {~half, half};
         end else if (wait_cnt != 2'h0) begin
            wait_cnt <= wait_cnt - 2'h1;
         end
      end
   end
endmodule // dbs_port_model

// [test/dynamic_bus_width_sizing_tb.sv]
/*
 dynamic_bus_width_sizing_tb: drives the core request port of dbs_sizer,
 records each bus cycle's lanes and write data, checks splits and data.
 Assumes dbs_port_model answers every cycle on the bus side.
*/
`timescale 1ns/10ps
module dynamic_bus_width_sizing_tb;
   logic clk, rst_n, req_valid, req_write, req_ready, bus_start_n, write_read_indicator;
   logic data_oe, ready_n, narrow_port_input_n, slow;
   logic [31:0] req_addr, req_wdata, req_rdata, data_out, data_in, rd;
   logic [1:0] req_len;
   logic [29:0] dword_address_lines;
   logic [3:0] byte_lane_selects_n;
   logic [15:0] seq;
   logic [31:0] dq [$];
   int failures, n_checks, ncyc, cyc;
   dbs_sizer DUT (.clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req_write(req_write),
      .req_addr(req_addr), .req_len(req_len), .req_wdata(req_wdata), .req_ready(req_ready),
      .req_rdata(req_rdata), .bus_start_n(bus_start_n), .dword_address_lines(dword_address_lines),
      .byte_lane_selects_n(byte_lane_selects_n), .write_read_indicator(write_read_indicator),
      .data_out(data_out), .data_oe(data_oe), .data_in(data_in), .ready_n(ready_n),
      .narrow_port_input_n(narrow_port_input_n));
   dbs_port_model mdl (.clk(clk), .rst_n(rst_n), .slow(slow), .bus_start_n(bus_start_n),
      .dword_address_lines(dword_address_lines), .byte_lane_selects_n(byte_lane_selects_n),
      .write_read_indicator(write_read_indicator), .data_out(data_out), .data_in(data_in),
      .ready_n(ready_n), .narrow_port_input_n(narrow_port_input_n));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task wrap_up;
      $display("checks=%0d mismatches=%0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // record lanes and data of each cycle at its start; flag gapped patterns
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         failures++;
         wrap_up;
      end
      if (rst_n && !bus_start_n) begin
         ncyc++;
         seq = {seq[11:0], byte_lane_selects_n};
         dq.push_back(data_out);
         chk({31'h0, byte_lane_selects_n inside {4'hf, 4'ha, 4'h5, 4'h6, 4'h4, 4'h2}},
            32'h0);
      end
   end
   // one operand transfer, then its cycle count and lane sequence
   task xfer(input logic w, input logic [31:0] a, input logic [1:0] len, input logic [31:0] wd,
         input int n, input logic [15:0] s);
      int k;
      @(negedge clk);
      ncyc = 0;
      seq = 16'h0;
      dq.delete();
      {req_valid, req_write, req_addr, req_len, req_wdata} = {1'b1, w, a, len, wd};
      for (k = 0; k < 200 && req_ready !== 1'b1; k++) @(negedge clk);
      rd = req_rdata;
      req_valid = 1'b0;
      chk(ncyc, n);
      chk({16'h0, seq}, {16'h0, s});
      chk({31'h0, req_ready}, 32'h1);
   endtask
   task t_reset;
      chk({25'h0, bus_start_n, byte_lane_selects_n, data_oe, req_ready},
         {25'h0, 1'b1, 4'hf, 1'b0, 1'b0});
   endtask
   task t_wide;
      xfer(1'b1, 32'h0, dbs_pkg::LEN_DWORD, 32'h44332211, 1, 16'h0);
      xfer(1'b0, 32'h0, dbs_pkg::LEN_DWORD, 32'h0, 1, 16'h0);
      chk(rd, 32'h44332211);
      xfer(1'b1, 32'h2, dbs_pkg::LEN_BYTE, 32'h000000a5, 1, 16'hb);
      chk(dq[0] & 32'h00ff00ff, 32'h00a500a5);
   endtask
   task t_narrow;
      xfer(1'b1, 32'h40, dbs_pkg::LEN_DWORD, 32'hd4c3b2a1, 2, 16'h03);
      chk(dq[0], 32'hd4c3b2a1);
      chk({16'h0, dq[1][15:0]}, 32'hd4c3);
      xfer(1'b0, 32'h40, dbs_pkg::LEN_DWORD, 32'h0, 2, 16'h03);
      chk(rd, 32'hd4c3b2a1);
      xfer(1'b1, 32'h42, dbs_pkg::LEN_WORD, 32'h00007766, 1, 16'h3);
      xfer(1'b0, 32'h42, dbs_pkg::LEN_WORD, 32'h0, 1, 16'h3);
      chk(rd & 32'h0000ffff, 32'h7766);
      xfer(1'b0, 32'h40, dbs_pkg::LEN_DWORD, 32'h0, 2, 16'h03);
      chk(rd, 32'h7766b2a1);
      xfer(1'b1, 32'h44, dbs_pkg::LEN_WORD, 32'h00009988, 1, 16'hc);
      xfer(1'b0, 32'h44, dbs_pkg::LEN_WORD, 32'h0, 1, 16'hc);
      chk(rd, 32'h9988);
   endtask
   task t_misalign;
      xfer(1'b1, 32'h1, dbs_pkg::LEN_DWORD, 32'h0d0c0b0a, 2, 16'he1);
      xfer(1'b0, 32'h1, dbs_pkg::LEN_DWORD, 32'h0, 2, 16'he1);
      chk(rd, 32'h0d0c0b0a);
      xfer(1'b1, 32'h43, dbs_pkg::LEN_DWORD, 32'h1f2e3d4c, 3, 16'h8b7);
      xfer(1'b0, 32'h43, dbs_pkg::LEN_DWORD, 32'h0, 3, 16'h8b7);
      chk(rd, 32'h1f2e3d4c);
   endtask
   task t_slow;
      slow = 1'b1;
      xfer(1'b0, 32'h43, dbs_pkg::LEN_DWORD, 32'h0, 3, 16'h8b7);
      chk(rd, 32'h1f2e3d4c);
      // spanning word on lanes 1 and 2 of the narrow port
      xfer(1'b1, 32'h45, dbs_pkg::LEN_WORD, 32'h0000bbaa, 2, 16'h9b);
      xfer(1'b0, 32'h45, dbs_pkg::LEN_WORD, 32'h0, 2, 16'h9b);
      chk(rd, 32'hbbaa);
      slow = 1'b0;
   endtask
   // main sequence; inputs change on the falling edge
   initial begin
      {rst_n, slow, req_valid, req_write, req_addr, req_len, req_wdata} = '0;
      failures = 0;
      n_checks = 0;
      cyc = 0;
      repeat (3) @(posedge clk);
      t_reset;
      @(negedge clk);
      rst_n = 1'b1;
      t_wide;
      t_narrow;
      t_misalign;
      t_slow;
      wrap_up;
   end
endmodule // dynamic_bus_width_sizing_tb
